// ==== rtl/dro_pkg.sv ====
// Shared constants and types for the receiver output stage.
// Assumes an APB master on pclk and a pixel link sampled on pclk.
package dro_pkg;
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] MASK_OFS = 8'h08;
   localparam logic [7:0] LINK_OFS = 8'h0c;
   localparam int         B_PPC    = 0;
   localparam int         B_EDGE   = 1;
   localparam int         B_FMT    = 2;
   localparam int         B_DRV    = 3;
   localparam int         B_STAGGER_N   = 4;
   localparam int         B_PDO    = 5;
   localparam int         B_PD     = 6;
   localparam int         CTRL_W   = 7;
   localparam logic [6:0] CTRL_RST = 7'h70;
   localparam int         EV_UP    = 0;
   localparam int         EV_DOWN  = 1;
   localparam int         EV_W     = 2;
   localparam int         INACT_PIX = 1000000;
   localparam int         WIN_PIX  = 1600;
   localparam int         CNT_W    = 20;
   localparam int         WIN_W    = 11;
   typedef enum logic [1:0] {
      LD_DOWN  = 2'b00,
      LD_ARMED = 2'b01,
      LD_UP    = 2'b11
   } dro_ld_e;
   typedef struct packed {
      logic        de;
      logic        hsync;
      logic        vsync;
      logic [2:0]  ctl;
      logic [23:0] rgb;
   } dro_vid_s;
endpackage : dro_pkg

// ==== rtl/dro_top.sv ====
// Output stage of a video link receiver: pixel formatting, output clock, power down
// and link activity detection, with APB registers and one interrupt.
// Assumes the decoder launches video_in on the falling edge of link_clk.
//
// Overview of operation
// - One pixel per clock when pixel select low, two when high; edge select.
// - Clock format 0 free-runs the output clock, 1 gates it low while DE is low (blanking).
// - Output power down floats all outputs except control 1 and link detect.
// - Decoding and link detection keep running during output power down.
// - Both power-down controls default to normal operation.
// - Drive strength select picks high or low output drive.
// - Stagger only acts in two-pixel mode, when stagger_n is low.
// - Staggered even pixels change a quarter output clock period later.
// - Full power down floats every output.
// - Full power down ignores all inputs except the power-down control.
// - Link detect falls after one million pixel clocks without a DE change.
// - Link detect rises after two DE changes within 1600 pixel clocks.
// - Link detect holds its state during full power down.
// - DE high marks active pixels, DE low marks blanking with controls.
// - Red on bits 23:16, green 15:8, blue 7:0 of both buses.
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ns
module dro_top #(
   parameter int unsigned INACT_CYCLES = dro_pkg::INACT_PIX
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic [31:0]           prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire logic             link_clk,
   input  wire dro_pkg::dro_vid_s video_in,
   output logic [23:0]           even_pixel_bus,
   output logic [23:0]           odd_pixel_bus,
   output logic                  de_out,
   output logic                  hsync_out,
   output logic                  vsync_out,
   output logic [1:0]            user_control_hi,
   output logic                  data_oe,
   output logic                  pixel_out_clock,
   output logic                  user_control_1,
   output logic                  user_control_1_oe,
   output logic                  link_active_detect,
   output logic                  link_detect_oe,
   output logic                  drive_strength_hi,
   output logic                  irq
);
   import dro_pkg::*;

   logic [2:0]        lck_ff;
   dro_vid_s          vs1_ff, vs2_ff;
   logic              rise, fall, live, tr;
   logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;
   logic [EV_W-1:0]   stat_ff, nxt_stat, mask_ff, nxt_mask, ev;
   logic [31:0]       prdata_ff, nxt_prdata;
   logic              pready_ff, nxt_pready, pslverr_ff, nxt_pslverr, irq_ff, nxt_irq;
   logic              acc, wr;
   logic [23:0]       even_ff, nxt_even, odd_ff, nxt_odd, hold_ff, nxt_hold;
   logic              de_ff, nxt_de, hs_ff, nxt_hs, vs_ff, nxt_vs;
   logic [2:0]        ctl_ff, nxt_ctl;
   logic              ck_ff, nxt_ck, phase_ff, nxt_phase, stg_ff, nxt_stg;
   logic              doe_ff, nxt_doe, c1oe_ff, nxt_c1oe, ldoe_ff, nxt_ldoe;
   logic              drv_ff, nxt_drv;
   dro_ld_e           st_ff, nxt_st;
   logic              live_q_ff, dprev_ff, nxt_dprev, det_ff, nxt_det;
   logic [CNT_W-1:0]  idle_ff, nxt_idle;
   logic [WIN_W-1:0]  win_ff, nxt_win;

   // Link clock and video pass two flops before any logic; lck_ff[2] only feeds edges.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lck_ff <= 3'h0;
         vs1_ff <= '0;
         vs2_ff <= '0;
      end else begin
         lck_ff <= {lck_ff[1:0], link_clk};
         vs1_ff <= video_in;
         vs2_ff <= vs1_ff;
      end
   end

   assign rise = lck_ff[1] & ~lck_ff[2];
   assign fall = ~lck_ff[1] & lck_ff[2];
   assign live = ctrl_ff[B_PD];
   assign acc  = psel & penable & pready_ff;
   assign wr   = acc & pwrite;
   assign tr   = rise & (vs2_ff.de != dprev_ff);

   // Register file. Read data is captured in the setup cycle and held until the next setup cycle.
   always_comb begin
      nxt_ctrl    = ctrl_ff;
      nxt_mask    = mask_ff;
      nxt_prdata  = prdata_ff;
      nxt_pready  = psel & ~penable;
      nxt_pslverr = 1'b0;
      nxt_stat    = stat_ff;
      if (wr && live && paddr == STAT_OFS) begin
         nxt_stat = stat_ff & ~pwdata[EV_W-1:0];
      end
      nxt_stat = nxt_stat | ev;
      if (psel && !penable) begin
         if (paddr == CTRL_OFS) begin
            nxt_prdata = {25'h0, ctrl_ff};
         end else if (paddr == STAT_OFS) begin
            nxt_prdata = {30'h0, stat_ff};
         end else if (paddr == MASK_OFS) begin
            nxt_prdata = {30'h0, mask_ff};
         end else if (paddr == LINK_OFS) begin
            nxt_prdata = {30'h0, vs2_ff.de, det_ff};
         end else begin
            nxt_prdata  = 32'h0;
            nxt_pslverr = 1'b1;
         end
      end
      if (wr && paddr == CTRL_OFS) begin
         if (live) begin
            nxt_ctrl = pwdata[CTRL_W-1:0];
         end else begin
            nxt_ctrl[B_PD] = pwdata[B_PD];
         end
      end
      if (wr && live && paddr == MASK_OFS) begin
         nxt_mask = pwdata[EV_W-1:0];
      end
      nxt_irq = |(nxt_stat & nxt_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_ff    <= CTRL_RST;
         stat_ff    <= '0;
         mask_ff    <= '0;
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         irq_ff     <= 1'b0;
      end else begin
         ctrl_ff    <= nxt_ctrl;
         stat_ff    <= nxt_stat;
         mask_ff    <= nxt_mask;
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr & psel;
         irq_ff     <= nxt_irq;
      end
   end

   // Pixel path. Only full power down stops it; output power down only floats pins.
   always_comb begin
      nxt_even  = even_ff;
      nxt_odd   = odd_ff;
      nxt_hold  = hold_ff;
      nxt_de    = de_ff;
      nxt_hs    = hs_ff;
      nxt_vs    = vs_ff;
      nxt_ctl   = ctl_ff;
      nxt_ck    = ck_ff;
      nxt_phase = phase_ff;
      nxt_stg   = stg_ff;
      if (live && rise) begin
         if (!ctrl_ff[B_PPC] || phase_ff) begin
            nxt_phase = 1'b0;
            nxt_de    = vs2_ff.de;
            nxt_hs    = vs2_ff.hsync;
            nxt_vs    = vs2_ff.vsync;
            nxt_ctl   = vs2_ff.ctl;
            nxt_ck    = ~ctrl_ff[B_EDGE] & ~(ctrl_ff[B_FMT] & ~vs2_ff.de);
            if (!ctrl_ff[B_PPC]) begin
               nxt_even = vs2_ff.rgb;
            end else begin
               nxt_odd = vs2_ff.rgb;
               if (!ctrl_ff[B_STAGGER_N]) begin
                  nxt_stg = 1'b1;
               end else begin
                  nxt_even = hold_ff;
               end
            end
         end else begin
            nxt_hold  = vs2_ff.rgb;
            nxt_phase = 1'b1;
            nxt_ck    = ctrl_ff[B_EDGE] & ~(ctrl_ff[B_FMT] & ~de_ff);
         end
      end
      if (live && fall) begin
         if (!ctrl_ff[B_PPC]) begin
            nxt_ck = ctrl_ff[B_EDGE] & ~(ctrl_ff[B_FMT] & ~de_ff);
         end
         // Half a pixel is a quarter of the two-pixel output clock period.
         if (stg_ff) begin
            nxt_even = hold_ff;
            nxt_stg  = 1'b0;
         end
      end
      nxt_doe  = live & ctrl_ff[B_PDO];
      nxt_c1oe = live;
      nxt_ldoe = live;
      nxt_drv  = ctrl_ff[B_DRV];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         even_ff  <= 24'h0;
         odd_ff   <= 24'h0;
         hold_ff  <= 24'h0;
         de_ff    <= 1'b0;
         hs_ff    <= 1'b0;
         vs_ff    <= 1'b0;
         ctl_ff   <= 3'h0;
         ck_ff    <= 1'b0;
         phase_ff <= 1'b0;
         stg_ff   <= 1'b0;
         doe_ff   <= 1'b0;
         c1oe_ff  <= 1'b0;
         ldoe_ff  <= 1'b0;
         drv_ff   <= 1'b0;
      end else begin
         even_ff  <= nxt_even;
         odd_ff   <= nxt_odd;
         hold_ff  <= nxt_hold;
         de_ff    <= nxt_de;
         hs_ff    <= nxt_hs;
         vs_ff    <= nxt_vs;
         ctl_ff   <= nxt_ctl;
         ck_ff    <= nxt_ck;
         phase_ff <= nxt_phase;
         stg_ff   <= nxt_stg;
         doe_ff   <= nxt_doe;
         c1oe_ff  <= nxt_c1oe;
         ldoe_ff  <= nxt_ldoe;
         drv_ff   <= nxt_drv;
      end
   end

   // Link activity detector, counted in pixel clocks. Frozen in full power down.
   always_comb begin
      nxt_st    = st_ff;
      nxt_dprev = dprev_ff;
      nxt_idle  = idle_ff;
      nxt_win   = win_ff;
      ev        = '0;
      if (live && !live_q_ff) begin
         nxt_st   = LD_DOWN;
         nxt_idle = '0;
      end else if (live && rise) begin
         nxt_dprev = vs2_ff.de;
         if (tr) begin
            nxt_idle = '0;
         end else if (idle_ff != CNT_W'(INACT_CYCLES)) begin
            nxt_idle = idle_ff + 1'b1;
         end
         case (st_ff)
            LD_DOWN: begin
               if (tr) begin
                  nxt_st  = LD_ARMED;
                  nxt_win = '0;
               end
            end
            LD_ARMED: begin
               if (tr) begin
                  nxt_st     = LD_UP;
                  ev[EV_UP]  = 1'b1;
               end else if (win_ff == WIN_W'(WIN_PIX - 1)) begin
                  nxt_st = LD_DOWN;
               end else begin
                  nxt_win = win_ff + 1'b1;
               end
            end
            LD_UP: begin
               if (!tr && idle_ff == CNT_W'(INACT_CYCLES - 1)) begin
                  nxt_st      = LD_DOWN;
                  ev[EV_DOWN] = 1'b1;
               end
            end
            default: begin
               nxt_st = LD_DOWN;
            end
         endcase
      end
      nxt_det = (nxt_st == LD_UP);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff     <= LD_DOWN;
         live_q_ff <= 1'b1;
         dprev_ff  <= 1'b0;
         idle_ff   <= '0;
         win_ff    <= '0;
         det_ff    <= 1'b0;
      end else begin
         st_ff     <= nxt_st;
         live_q_ff <= live;
         dprev_ff  <= nxt_dprev;
         idle_ff   <= nxt_idle;
         win_ff    <= nxt_win;
         det_ff    <= nxt_det;
      end
   end

   assign prdata             = prdata_ff;
   assign pready             = pready_ff;
   assign pslverr            = pslverr_ff;
   assign even_pixel_bus     = even_ff;
   assign odd_pixel_bus      = odd_ff;
   assign de_out             = de_ff;
   assign hsync_out          = hs_ff;
   assign vsync_out          = vs_ff;
   assign user_control_hi    = ctl_ff[2:1];
   assign user_control_1     = ctl_ff[0];
   assign data_oe            = doe_ff;
   assign pixel_out_clock    = ck_ff;
   assign user_control_1_oe  = c1oe_ff;
   assign link_active_detect = det_ff;
   assign link_detect_oe     = ldoe_ff;
   assign drive_strength_hi  = drv_ff;
   assign irq                = irq_ff;

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_PD_HIZ: assert property (!live |=> !doe_ff && !c1oe_ff && !ldoe_ff)
      else $error("outputs driven in full power down");
   AST_PDO: assert property (live && !ctrl_ff[B_PDO] |=> !doe_ff && c1oe_ff && ldoe_ff)
      else $error("wrong enables in output power down");
   AST_PIX1: assert property (live && rise && !ctrl_ff[B_PPC]
      |=> even_ff == $past(vs2_ff.rgb) && ck_ff == !$past(ctrl_ff[B_EDGE] || !vs2_ff.de && ctrl_ff[B_FMT]))
      else $error("one-pixel output wrong");
   AST_GATE: assert property (live && rise && ctrl_ff[B_FMT] && !vs2_ff.de
      && (!ctrl_ff[B_PPC] || phase_ff) |=> !ck_ff ##1 !ck_ff)
      else $error("output clock not gated low in blanking");
   AST_PIX2: assert property (live && rise && ctrl_ff[B_PPC] && phase_ff
      |=> odd_ff == $past(vs2_ff.rgb) && !phase_ff)
      else $error("odd pixel not presented");
   AST_NOSTAG: assert property (live && rise && ctrl_ff[B_PPC] && phase_ff && ctrl_ff[B_STAGGER_N]
      |=> even_ff == $past(hold_ff))
      else $error("even pixel late without stagger");
   AST_STAGGER_N: assert property (live && rise && ctrl_ff[B_PPC] && phase_ff && !ctrl_ff[B_STAGGER_N]
      |=> $stable(even_ff) && stg_ff)
      else $error("even pixel not staggered");
   AST_FREEZE: assert property (!live |=> $stable(det_ff) && $stable(st_ff))
      else $error("link detect moved in full power down");
   AST_UP: assert property (live && live_q_ff && st_ff == LD_ARMED && tr |=> det_ff)
      else $error("link detect did not rise");
   AST_DOWN: assert property (live && live_q_ff && rise && st_ff == LD_UP && !tr
      && idle_ff == CNT_W'(INACT_CYCLES - 1) |=> !det_ff)
      else $error("link detect did not fall");
   AST_EXIT: assert property (live && !live_q_ff |=> !det_ff)
      else $error("link detect high on power-up exit");
   COV_UP: cover property (!det_ff ##1 det_ff);
   COV_STAGGER_N: cover property (stg_ff && fall);
   COV_PD: cover property (!live ##1 live);
endmodule : dro_top

// ==== tb/dro_panel_model.sv ====
// Panel timing controller model: latches the pixel buses on the chosen output clock edge.
// Assumes the output clock and buses are registered outputs in the pclk domain.
`timescale 1ns/1ns
module dro_panel_model (
   input  wire logic        pclk,
   input  wire logic        rise_latch,
   input  wire logic        ck,
   input  wire logic        oe,
   input  wire logic [23:0] even_bus,
   input  wire logic [23:0] odd_bus,
   input  wire logic        de,
   output logic [23:0]      got_even,
   output logic [23:0]      got_odd,
   output logic             got_de
);
   logic ck_d = 1'b0;
   // Link detect is never routed to full power down by this panel side.
   // Only a driven bus is latched, since a floated bus carries no pixel.
   always @(posedge pclk) begin
      ck_d <= ck;
      if (oe === 1'b1 && ck !== ck_d && ck === rise_latch) begin
         got_even <= even_bus;
         got_odd  <= odd_bus;
         got_de   <= de;
      end
   end
endmodule : dro_panel_model

// ==== tb/tb.sv ====
// Testbench for dro_top: registers, pixel modes, power down and link detect.
// Assumes the panel model and a shortened inactivity count of 200 pixel clocks.
`timescale 1ns/1ns
module tb;
   import dro_pkg::*;
   localparam int INACT = 200;
   logic        pclk     = 1'b0;
   logic        presetn  = 1'b0;
   logic        psel     = 1'b0;
   logic        penable  = 1'b0;
   logic        pwrite   = 1'b0;
   logic [7:0]  paddr    = 8'h00;
   logic [31:0] pwdata   = 32'h0;
   logic        link_clk = 1'b0;
   logic        alt      = 1'b0;
   logic        edge_sel = 1'b0;
   dro_vid_s    video_in = '0;
   dro_vid_s    vid_nx   = '0;
   logic [31:0] prdata, rd;
   logic [23:0] even_bus, odd_bus, g_even, g_odd;
   logic [1:0]  uc_hi;
   logic        pready, pslverr, er, de_out, hs, vs, data_oe, ck, uc1, uc1_oe;
   logic        det, det_oe, drv, irq, g_de;
   int          mismatches = 0;
   int          compares   = 0;

   dro_top #(.INACT_CYCLES(INACT)) dro_top_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_clk(link_clk),
      .video_in(video_in), .even_pixel_bus(even_bus), .odd_pixel_bus(odd_bus),
      .de_out(de_out), .hsync_out(hs), .vsync_out(vs), .user_control_hi(uc_hi),
      .data_oe(data_oe), .pixel_out_clock(ck), .user_control_1(uc1),
      .user_control_1_oe(uc1_oe), .link_active_detect(det), .link_detect_oe(det_oe),
      .drive_strength_hi(drv), .irq(irq));
   dro_panel_model dro_panel_model_inst (.pclk(pclk), .rise_latch(edge_sel), .ck(ck),
      .oe(data_oe), .even_bus(even_bus), .odd_bus(odd_bus), .de(de_out),
      .got_even(g_even), .got_odd(g_odd), .got_de(g_de));

   always #10 pclk = ~pclk;
   initial begin
      #7;
      forever #80 link_clk = ~link_clk;
   end
   // Video launches on the link falling edge so it is stable at the rising edge.
   always @(negedge link_clk) begin
      video_in <= vid_nx;
      if (alt) vid_nx.rgb <= ~vid_nx.rgb;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Sample on the falling edge so the value seen is the one at the next rising edge.
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      chk(pready, 1'b1);
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse_de;
      @(posedge pclk);
      vid_nx.de <= 1'b1;
      wt(24);
      vid_nx.de <= 1'b0;
      wt(24);
   endtask : pulse_de

   task automatic wait_det(input logic v, input int lim);
      int n;
      n = 0;
      while (det !== v && n < lim) begin
         @(posedge pclk);
         n++;
      end
      chk(det, v);
   endtask : wait_det

   task automatic t_regs;
      chk(det, 1'b0);
      apb(1'b0, CTRL_OFS, 32'h0);
      chk(rd, 32'h70);
      apb(1'b0, 8'h10, 32'h0);
      chk({er, rd[30:0]}, 32'h80000000);
      apb(1'b1, CTRL_OFS, 32'h78);
      wt(2);
      chk(drv, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h70);
      wt(2);
      chk(drv, 1'b0);
   endtask : t_regs

   task automatic t_link;
      apb(1'b1, MASK_OFS, 32'h3);
      apb(1'b1, CTRL_OFS, 32'h50);
      wt(4);
      chk({data_oe, uc1_oe, det_oe}, 3'b011);
      pulse_de();
      wait_det(1'b1, 100);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(rd[1:0], 2'b01);
      chk(irq, 1'b1);
      apb(1'b1, STAT_OFS, 32'h1);
      wt(2);
      chk(irq, 1'b0);
      wt(INACT * 6 - 200);
      chk(det, 1'b1);
      wait_det(1'b0, 1000);
      apb(1'b0, STAT_OFS, 32'h0);
      chk(rd[1:0], 2'b10);
      apb(1'b1, STAT_OFS, 32'h3);
      apb(1'b1, CTRL_OFS, 32'h70);
   endtask : t_link

   task automatic t_one;
      for (int e = 0; e < 2; e++) begin
         apb(1'b1, CTRL_OFS, 32'h70 | (e << 1));
         @(posedge pclk);
         edge_sel <= 1'(e);
         vid_nx.de <= 1'b1;
         vid_nx.rgb <= 24'h123456 + 24'(e);
         wt(64);
         chk(g_even, 24'h123456 + 24'(e));
         chk({g_de, de_out}, 2'b11);
      end
      edge_sel <= 1'b0;
   endtask : t_one

   task automatic t_two;
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, CTRL_OFS, s ? 32'h61 : 32'h71);
         @(posedge pclk);
         vid_nx.rgb <= 24'h5ac30f;
         alt <= 1'b1;
         wt(80);
         chk(even_bus ^ odd_bus, 24'hffffff);
         chk(g_even ^ g_odd, 24'hffffff);
      end
      alt <= 1'b0;
   endtask : t_two

   task automatic t_gate;
      int n;
      apb(1'b1, CTRL_OFS, 32'h74);
      @(posedge pclk);
      vid_nx <= '{de: 1'b0, hsync: 1'b1, vsync: 1'b0, ctl: 3'b110, rgb: 24'h0};
      wt(40);
      chk({hs, vs, uc_hi, uc1}, 5'b10110);
      for (int f = 0; f < 2; f++) begin
         if (f == 1) apb(1'b1, CTRL_OFS, 32'h70);
         n = 0;
         repeat (64) begin
            @(posedge pclk);
            if (ck === 1'b1) n++;
         end
         chk(n > 0, f);
      end
   endtask : t_gate

   task automatic t_pd;
      pulse_de();
      wait_det(1'b1, 100);
      apb(1'b1, CTRL_OFS, 32'h30);
      wt(4);
      chk({data_oe, uc1_oe, det_oe}, 3'b000);
      apb(1'b1, MASK_OFS, 32'h0);
      pulse_de();
      wt(INACT * 8 + 400);
      chk(det, 1'b1);
      apb(1'b1, CTRL_OFS, 32'h70);
      wt(4);
      chk({det, det_oe}, 2'b01);
      apb(1'b0, MASK_OFS, 32'h0);
      chk(rd, 32'h3);
   endtask : t_pd

   task automatic close_out;
      $display("mismatches=%0d compares=%0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_link();
      t_one();
      t_two();
      t_gate();
      t_pd();
      close_out();
   end

   // The whole sequence needs well under 10000 pclk cycles.
   initial begin
      #400000;
      mismatches++;
      close_out();
   end
endmodule : tb
